// ---- srp_pkg.sv ----
// Shared constants and carriers for the read port output block
package srp_pkg;

  localparam int SRP_WORD_W = 18;
  localparam int SRP_ADDR_W = 18;
  localparam int SRP_BURST_LEN = 4;
  localparam int SRP_DATA_DEPTH = 32;
  localparam int SRP_REQ_DEPTH = 32;
  localparam int SRP_SYNC_STAGES = 2;
  localparam logic [SRP_WORD_W-1:0] SRP_Q_RESET = 18'h00000;
  localparam logic [SRP_ADDR_W-1:0] SRP_ADDR_RESET = 18'h00000;

  // One launch edge pair: rise word on the positive clock, fall word on the negative
  typedef struct packed {
    logic [SRP_WORD_W-1:0] fall;
    logic [SRP_WORD_W-1:0] rise;
  } srp_pair_s;

  // One whole read burst of four words, first pair leaves first
  typedef struct packed {
    srp_pair_s second;
    srp_pair_s first;
  } srp_burst_s;

endpackage

// ---- srp_async_fifo.sv ----
// Dual-clock FIFO with gray-coded pointer crossing
`timescale 1ns/1ps
module srp_async_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 32
) (
  // Write side
  input wire logic i_wclk,
  input wire logic i_wrst,
  input wire logic i_wvalid,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic o_wready,
  // Read side
  input wire logic i_rclk,
  input wire logic i_rrst,
  output logic o_rvalid,
  output logic [WIDTH-1:0] o_rdata,
  input wire logic i_rready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin, next_wbin, wgray, next_wgray;
  logic [AW:0] rbin, next_rbin, rgray, next_rgray;
  logic [AW:0] rgray_meta, rgray_sync, wgray_meta, wgray_sync;
  logic next_wready, next_rvalid;
  logic push, pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  assign push = i_wvalid && o_wready;
  assign pop = i_rready && o_rvalid;
  assign o_rdata = mem[rbin[AW-1:0]];

  always_comb begin
    next_wbin = wbin + (AW+1)'(push);
    next_wgray = to_gray(next_wbin);
    // Full when write pointer is one lap ahead of the read pointer
    next_wready = next_wgray != {~rgray_sync[AW:AW-1], rgray_sync[AW-2:0]};
    if (i_wrst) begin
      next_wbin = '0;
      next_wgray = '0;
      next_wready = 1'b0;
    end
  end

  always_ff @(posedge i_wclk) begin
    rgray_meta <= rgray;
    rgray_sync <= rgray_meta;
    wbin <= next_wbin;
    wgray <= next_wgray;
    o_wready <= next_wready;
    if (push) begin
      mem[wbin[AW-1:0]] <= i_wdata;
    end
  end

  always_comb begin
    next_rbin = rbin + (AW+1)'(pop);
    next_rgray = to_gray(next_rbin);
    next_rvalid = next_rgray != wgray_sync;
    if (i_rrst) begin
      next_rbin = '0;
      next_rgray = '0;
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_rclk) begin
    wgray_meta <= wgray;
    wgray_sync <= wgray_meta;
    rbin <= next_rbin;
    rgray <= next_rgray;
    o_rvalid <= next_rvalid;
  end

endmodule

// ---- srp_read_port.sv ----
// Read port output side: request capture, burst buffering and DDR launch
//
// Notes on behaviour
// - Drive read data only while read active
// - One word per positive and negative edge
// - Select low at positive edge starts read
// - Deselect still finishes the burst in flight
// - Outputs float after burst, next positive edge
// - Every request yields four sequential words; here a select while the request queue is full is dropped
// - Valid flag high exactly with burst data
// - Valid flag changes with echo clock edges; here it is registered on the i_k_clk rise
// - Accesses start on positive edge only
// - Address taken with select; ignored when deselected
`timescale 1ns/1ps
module srp_read_port
  import srp_pkg::*;
#(
  parameter int ADDR_W = SRP_ADDR_W,
  parameter int DATA_DEPTH = SRP_DATA_DEPTH,
  parameter int REQ_DEPTH = SRP_REQ_DEPTH
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Core read requests
  output logic o_req_valid,
  output logic [ADDR_W-1:0] o_req_addr,
  input wire logic i_req_ready,
  // Core burst data
  input wire logic i_burst_valid,
  input srp_burst_s i_burst,
  output logic o_burst_ready,
  // Link side, positive input clock domain
  input wire logic i_k_clk,
  input wire logic i_read_port_select_n,
  input wire logic [ADDR_W-1:0] i_addr,
  output srp_pair_s o_q,
  output logic o_q_oe,
  output logic o_read_valid_flag
);

  typedef enum logic [1:0] {LK_IDLE, LK_FIRST, LK_SECOND} srp_link_e;

  // Link reset chain; first stage feeds only the second
  logic k_rst_meta, k_rst;

  always_ff @(posedge i_k_clk) begin
    k_rst_meta <= i_rst;
    k_rst <= k_rst_meta;
  end

  // Request path: link domain into core domain
  logic req_push, req_wready, req_rvalid, req_rready;
  logic [ADDR_W-1:0] req_rdata;
  logic next_req_valid;
  logic [ADDR_W-1:0] next_req_addr;

  // Address only enters the queue with an active select
  assign req_push = !i_read_port_select_n;

  srp_async_fifo #(
    .WIDTH(ADDR_W),
    .DEPTH(REQ_DEPTH)
  ) u_req_fifo (
    .i_wclk(i_k_clk),
    .i_wrst(k_rst),
    .i_wvalid(req_push),
    .i_wdata(i_addr),
    .o_wready(req_wready),
    .i_rclk(i_clk),
    .i_rrst(i_rst),
    .o_rvalid(req_rvalid),
    .o_rdata(req_rdata),
    .i_rready(req_rready)
  );

  assign req_rready = !o_req_valid || i_req_ready;

  always_comb begin
    next_req_valid = o_req_valid;
    next_req_addr = o_req_addr;
    if (req_rready) begin
      next_req_valid = req_rvalid;
      next_req_addr = req_rvalid ? req_rdata : o_req_addr;
    end
    if (i_rst) begin
      next_req_valid = 1'b0;
      next_req_addr = SRP_ADDR_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    o_req_valid <= next_req_valid;
    o_req_addr <= next_req_addr;
  end

  // Data path: core domain into link domain, one entry per burst
  logic data_rvalid, data_pop;
  srp_burst_s data_rdata;

  srp_async_fifo #(
    .WIDTH($bits(srp_burst_s)),
    .DEPTH(DATA_DEPTH)
  ) u_data_fifo (
    .i_wclk(i_clk),
    .i_wrst(i_rst),
    .i_wvalid(i_burst_valid),
    .i_wdata(i_burst),
    .o_wready(o_burst_ready),
    .i_rclk(i_k_clk),
    .i_rrst(k_rst),
    .o_rvalid(data_rvalid),
    .o_rdata(data_rdata),
    .i_rready(data_pop)
  );

  // Link launch machine: two positive-clock cycles per burst
  srp_link_e state, next_state;
  srp_pair_s hold, next_hold, next_q;
  logic next_oe, next_valid;

  always_comb begin
    next_state = state;
    next_hold = hold;
    next_q = o_q;
    next_oe = 1'b0;
    next_valid = 1'b0;
    data_pop = 1'b0;
    unique case (state)
      LK_IDLE, LK_SECOND: begin
        if (data_rvalid) begin
          next_state = LK_FIRST;
          next_q = data_rdata.first;
          next_hold = data_rdata.second;
          next_oe = 1'b1;
          next_valid = 1'b1;
          data_pop = 1'b1;
        end else begin
          // No burst waiting in the data queue: float on this edge
          next_state = LK_IDLE;
        end
      end
      LK_FIRST: begin
        // Second pair goes out whatever the select does now
        next_state = LK_SECOND;
        next_q = hold;
        next_oe = 1'b1;
        next_valid = 1'b1;
      end
      default: begin
        // Unused code of the two-bit state: recover to idle
        next_state = LK_IDLE;
      end
    endcase
    if (k_rst) begin
      next_state = LK_IDLE;
      next_hold = '{default: SRP_Q_RESET};
      next_q = '{default: SRP_Q_RESET};
      next_oe = 1'b0;
      next_valid = 1'b0;
    end
  end

  // Valid and data share the same positive edge of the link clock
  always_ff @(posedge i_k_clk) begin
    state <= next_state;
    hold <= next_hold;
    o_q <= next_q;
    o_q_oe <= next_oe;
    o_read_valid_flag <= next_valid;
  end

  // Helper: bursts requested but not yet launched, for checking only
  logic [7:0] pend, next_pend;
  logic req_taken;

  assign req_taken = req_push && req_wready;

  always_comb begin
    next_pend = pend + 8'(req_taken) - 8'(data_pop);
    if (k_rst) begin
      next_pend = 8'h00;
    end
  end

  always_ff @(posedge i_k_clk) begin
    pend <= next_pend;
  end

  default clocking k_cb @(posedge i_k_clk);
  endclocking
  default disable iff (k_rst);

  drive_needs_valid_a: assert property (o_q_oe |-> o_read_valid_flag)
    else $error("Data driven without valid flag");

  valid_needs_drive_a: assert property (o_read_valid_flag |-> o_q_oe)
    else $error("Valid flag without driven data");

  second_pair_a: assert property ((state == LK_FIRST) |=> o_q == $past(hold))
    else $error("Second pair is not the held words");

  burst_started_a: assert property ((state == LK_FIRST) |-> $past(pend) != 8'h00)
    else $error("Burst launched with no accepted request");

  burst_finish_a: assert property ((state == LK_FIRST && i_read_port_select_n)
      |=> o_read_valid_flag && o_q_oe)
    else $error("Deselect cut a burst short");

  float_after_a: assert property ((state == LK_SECOND && !data_rvalid) |=> !o_q_oe)
    else $error("Outputs not floated after the burst");

  burst_two_cycles_a: assert property ($rose(o_q_oe) |-> o_q_oe [*2])
    else $error("Burst shorter than four words");

  valid_with_state_a: assert property (o_read_valid_flag == (state != LK_IDLE))
    else $error("Valid flag off the launch edge");

  reset_float_a: assert property ($fell(k_rst) |-> !o_q_oe && !o_read_valid_flag)
    else $error("Outputs active right after reset");

endmodule

// ---- srp_ctrl_model.sv ----
// Memory controller model that issues link reads and collects returned words
`timescale 1ns/1ps
module srp_ctrl_model
  import srp_pkg::*;
(
  // Link clock
  input wire logic i_k_clk,
  // Returned read data
  input srp_pair_s i_q,
  input wire logic i_q_oe,
  input wire logic i_read_valid_flag,
  // Read request
  output logic o_read_port_select_n,
  output logic [SRP_ADDR_W-1:0] o_addr
);
  logic [SRP_WORD_W-1:0] words[$];
  int oe_bad = 0;

  initial begin
    o_read_port_select_n = 1'b1;
    o_addr = '0;
  end

  // Capture on the K rise, the same edge the flag follows
  always @(posedge i_k_clk) begin
    if (i_q_oe !== i_read_valid_flag) oe_bad++;
    if (i_read_valid_flag === 1'b1) begin
      words.push_back(i_q.rise);
      words.push_back(i_q.fall);
    end
  end

  task automatic issue(input logic [SRP_ADDR_W-1:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_k_clk);
      o_read_port_select_n <= 1'b0;
      o_addr <= a + SRP_ADDR_W'(4 * i);
    end
    @(posedge i_k_clk);
    o_read_port_select_n <= 1'b1;
    // Address is ignored when deselected, so it must not stay meaningful
    o_addr <= ~o_addr;
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the read port output block
`timescale 1ns/1ps
module testbench;
  import srp_pkg::*;
  typedef struct {logic [17:0] addr; int n;} srp_row_s;
  srp_row_s rows[4] = '{'{18'h00000, 1}, '{18'h3FFFC, 1}, '{18'h12345, 2}, '{18'h2AAAA, 3}};
  logic i_clk = 1'b0;
  logic i_k_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_ready = 1'b0;
  logic i_burst_valid = 1'b0;
  srp_burst_s i_burst = '0;
  logic o_req_valid, o_burst_ready, o_q_oe, o_read_valid_flag, sel_n;
  logic [17:0] o_req_addr, addr;
  srp_pair_s o_q;
  logic [17:0] pend[$];
  int failures = 0;
  int num_checks = 0;

  srp_read_port srp_read_port_i (.i_clk(i_clk), .i_rst(i_rst), .o_req_valid(o_req_valid),
    .o_req_addr(o_req_addr), .i_req_ready(i_req_ready), .i_burst_valid(i_burst_valid),
    .i_burst(i_burst), .o_burst_ready(o_burst_ready), .i_k_clk(i_k_clk),
    .i_read_port_select_n(sel_n), .i_addr(addr), .o_q(o_q), .o_q_oe(o_q_oe),
    .o_read_valid_flag(o_read_valid_flag));
  srp_ctrl_model srp_ctrl_model_i (.i_k_clk(i_k_clk), .i_q(o_q), .i_q_oe(o_q_oe),
    .i_read_valid_flag(o_read_valid_flag), .o_read_port_select_n(sel_n), .o_addr(addr));

  initial forever #20 i_clk = ~i_clk;
  initial forever #3 i_k_clk = ~i_k_clk;

  // Core side: burst word k of address a is a + k
  always @(posedge i_clk) begin
    if (i_rst) begin
      i_req_ready <= 1'b0;
      i_burst_valid <= 1'b0;
    end else begin
      // Stall every other cycle to exercise the request handshake
      i_req_ready <= ~i_req_ready;
      if (o_req_valid && i_req_ready) pend.push_back(o_req_addr);
      if (!i_burst_valid || o_burst_ready) begin
        i_burst_valid <= (pend.size() != 0);
        if (pend.size() != 0) i_burst <= mk(pend.pop_front());
      end
    end
  end

  function automatic srp_burst_s mk(input logic [17:0] a);
    mk.first.rise = a;
    mk.first.fall = a + 18'h00001;
    mk.second.rise = a + 18'h00002;
    mk.second.fall = a + 18'h00003;
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic run(input logic [17:0] a, input int n);
    int k;
    srp_ctrl_model_i.issue(a, n);
    k = 0;
    while (srp_ctrl_model_i.words.size() < 4 * n && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    for (int j = 0; j < 4 * n; j++) check(36'(srp_ctrl_model_i.words.pop_front()), 36'(a + 18'(j)));
    repeat (4) @(posedge i_clk);
    check(36'(o_q_oe), 36'h0);
    check(36'(o_read_valid_flag), 36'h0);
  endtask

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    check(36'(o_q_oe), 36'h0);
    check(36'(o_read_valid_flag), 36'h0);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_k_clk);
    check(36'(o_q_oe), 36'h0);
    foreach (rows[r]) run(rows[r].addr, rows[r].n);
    check(36'(srp_ctrl_model_i.words.size()), 36'h0);
    check(36'(srp_ctrl_model_i.oe_bad), 36'h0);
    // Reset again in mid-run, then one more burst must still come through
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(36'(o_q_oe), 36'h0);
    check(36'(o_read_valid_flag), 36'h0);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_k_clk);
    check(36'(o_q_oe), 36'h0);
    run(18'h15550, 1);
    end_of_test();
  end

  // Whole run needs a few microseconds; this leaves wide margin
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
